// File: rtl/tch_ctrl.sv
`timescale 1ns/10ps
module tch_ctrl #(
  parameter int STEP_CYCLES = tch_pkg::STEP_CYCLES_DEF
) (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire tch_pkg::tch_reg_s REG_REQ,
  output logic [7:0] REG_RDATA,
  input wire logic [7:0] TOUCH_DET,
  input wire logic [7:0] NOISE_FLAG,
  input wire logic [7:0] NEW_ENABLE,
  input wire logic RELEASE_INT_EN,
  input wire logic [3:0] REPEAT_CODE,
  input wire logic [3:0] HOLD_CODE,
  input wire logic STATUS_CLEAR,
  input wire logic CAL_DONE,
  input wire logic [9:0] CAL_RESULT,
  output tch_pkg::tch_cal_s CAL_CMD,
  output logic [79:0] CAL_VALUES,
  output logic [7:0] TOUCH_STATUS,
  output logic MULTI_TOUCH,
  output logic CAL_FAIL,
  output logic ALERT_N
);
  import tch_pkg::*;
  localparam int TW = $clog2(STEP_CYCLES);

  function automatic logic [7:0] first_n(input logic [7:0] v,
                                         input logic [3:0] n);
    logic [7:0] r;
    logic [3:0] c;
    r = '0;
    c = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (v[i] && (c < n)) begin
        r[i] = 1'b1;
        c = c + 4'h1;
      end
    end
    return r;
  endfunction

  // Register file
  logic [7:0] mask_q, mask_d, rpt_q, rpt_d, mt_q, mt_d, rdata_q, rdata_d;
  logic wr_cal;

  assign wr_cal = REG_REQ.wr && (REG_REQ.addr == ADDR_CAL);
  assign REG_RDATA = rdata_q;

  // Calibration sequencer state
  tch_cal_e st_q, st_d;
  logic [7:0] cal_q, cal_d, tried_q, tried_d, pend;
  logic [CAL_W-1:0] val_q [NUM_IN];
  logic [CAL_W-1:0] val_d [NUM_IN];
  tch_cal_s cmd_q, cmd_d;
  logic fail_q, fail_d, cal_ok;

  always_comb begin
    mask_d = mask_q;
    rpt_d = rpt_q;
    mt_d = mt_q;
    rdata_d = rdata_q;
    if (REG_REQ.wr) begin
      case (REG_REQ.addr)
        ADDR_MASK: mask_d = REG_REQ.wdata;
        ADDR_RPT: rpt_d = REG_REQ.wdata;
        ADDR_MT: mt_d = REG_REQ.wdata & MT_WMASK;
        default: mask_d = mask_q;
      endcase
    end
    if (REG_REQ.rd) begin
      case (REG_REQ.addr)
        ADDR_CAL: rdata_d = cal_q;
        ADDR_MASK: rdata_d = mask_q;
        ADDR_RPT: rdata_d = rpt_q;
        ADDR_MT: rdata_d = mt_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_q <= RST_MASK;
      rpt_q <= RST_RPT;
      mt_q <= RST_MT;
      rdata_q <= 8'h00;
    end else begin
      mask_q <= mask_d;
      rpt_q <= rpt_d;
      mt_q <= mt_d;
      rdata_q <= rdata_d;
    end
  end

  assign pend = cal_q & ~tried_q;
  assign cal_ok = !NOISE_FLAG[cmd_q.sel] && (CAL_RESULT != CAL_MAX)
                  && (CAL_RESULT != CAL_MIN);

  always_comb begin
    st_d = st_q;
    cal_d = cal_q;
    tried_d = tried_q;
    cmd_d = cmd_q;
    cmd_d.start = 1'b0;
    fail_d = fail_q;
    for (int i = 0; i < NUM_IN; i++) begin
      val_d[i] = val_q[i];
    end
    if (STATUS_CLEAR) begin
      fail_d = 1'b0;
    end
    if (wr_cal) begin
      // Ones request calibration, zeros cancel pending ones
      cal_d = REG_REQ.wdata;
      tried_d = tried_q & ~REG_REQ.wdata;
    end
    case (st_q)
      CAL_IDLE: begin
        if (pend != 8'h00) begin
          for (int i = NUM_IN - 1; i >= 0; i--) begin
            if (pend[i]) begin
              cmd_d.sel = 3'(i);
            end
          end
          cmd_d.start = 1'b1;
          st_d = CAL_WAIT;
        end
      end
      CAL_WAIT: begin
        if (CAL_DONE) begin
          val_d[cmd_q.sel] = CAL_RESULT;
          tried_d[cmd_q.sel] = 1'b1;
          if (cal_ok) begin
            if (!(wr_cal && REG_REQ.wdata[cmd_q.sel])) begin
              cal_d[cmd_q.sel] = 1'b0;
            end
          end else begin
            fail_d = 1'b1;
          end
          st_d = CAL_IDLE;
        end
      end
      default: st_d = CAL_IDLE;
    endcase
    // Hardware set wins over a host clear in the same cycle
    cal_d = cal_d | NEW_ENABLE;
    tried_d = tried_d & ~NEW_ENABLE;
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      st_q <= CAL_IDLE;
      cal_q <= RST_CAL;
      tried_q <= 8'h00;
      cmd_q <= '0;
      fail_q <= 1'b0;
      for (int i = 0; i < NUM_IN; i++) begin
        val_q[i] <= '0;
      end
    end else begin
      st_q <= st_d;
      cal_q <= cal_d;
      tried_q <= tried_d;
      cmd_q <= cmd_d;
      fail_q <= fail_d;
      for (int i = 0; i < NUM_IN; i++) begin
        val_q[i] <= val_d[i];
      end
    end
  end

  assign CAL_CMD = cmd_q;
  assign CAL_FAIL = fail_q;

  // Simultaneous-touch blocking
  logic blk_en;
  logic [3:0] lim, kept_cnt;
  logic [7:0] sel_q, sel_d, acc_kept;
  logic multi_touch_status_q, multi_touch_status_d;

  assign blk_en = mt_q[MT_EN_BIT];
  assign lim = {2'b00, mt_q[MT_LIM_LSB +: MT_LIM_W]} + 4'h1;
  assign acc_kept = sel_q & TOUCH_DET;
  assign kept_cnt = 4'($countones(acc_kept));

  always_comb begin
    sel_d = TOUCH_DET;
    if (blk_en) begin
      if ((sel_q & ~TOUCH_DET) != 8'h00) begin
        sel_d = first_n(TOUCH_DET, lim);
      end else if (kept_cnt >= lim) begin
        sel_d = first_n(acc_kept, lim);
      end else begin
        sel_d = acc_kept
              | first_n(TOUCH_DET & ~acc_kept, lim - kept_cnt);
      end
    end
    multi_touch_status_d = blk_en && ((TOUCH_DET & ~sel_d) != 8'h00);
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sel_q <= 8'h00;
      multi_touch_status_q <= 1'b0;
    end else begin
      sel_q <= sel_d;
      multi_touch_status_q <= multi_touch_status_d;
    end
  end

  assign TOUCH_STATUS = sel_q;
  assign MULTI_TOUCH = multi_touch_status_q;

  // Step tick and per-input event timers
  logic [TW-1:0] step_q, step_d;
  logic tick;
  logic [7:0] evt;

  assign tick = (step_q == TW'(STEP_CYCLES - 1));

  always_comb begin
    step_d = tick ? '0 : step_q + TW'(1);
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      step_q <= '0;
    end else begin
      step_q <= step_d;
    end
  end

  for (genvar g = 0; g < NUM_IN; g++) begin : g_in
    tch_rpt u_rpt (
      .clk(SYS_CLK),
      .rst_n(ARST_N),
      .touch(sel_q[g]),
      .tick(tick),
      .rpt_en(rpt_q[g]),
      .rel_en(RELEASE_INT_EN),
      .hold_code(HOLD_CODE),
      .rate_code(REPEAT_CODE),
      .evt(evt[g])
    );
    assign CAL_VALUES[g*CAL_W +: CAL_W] = val_q[g];
  end

  // Alert output, event wins over a clear
  logic alert_n_q, alert_n_d;

  always_comb begin
    alert_n_d = alert_n_q;
    if (STATUS_CLEAR) begin
      alert_n_d = 1'b1;
    end
    if ((evt & mask_q) != 8'h00) begin
      alert_n_d = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= alert_n_d;
    end
  end

  assign ALERT_N = alert_n_q;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!ARST_N);

  cal_write_a: assert property (wr_cal |=>
    ((cal_q & $past(REG_REQ.wdata)) == $past(REG_REQ.wdata)))
    else $error("calibration request write not stored");
  cal_value_a: assert property ((st_q == CAL_WAIT) && CAL_DONE |=>
    (val_q[$past(cmd_q.sel)] == $past(CAL_RESULT)))
    else $error("calibration value not updated");
  cal_clear_a: assert property ((st_q == CAL_WAIT) && CAL_DONE && cal_ok
    && !wr_cal && (NEW_ENABLE == 8'h00) |=> !cal_q[$past(cmd_q.sel)])
    else $error("calibration request not cleared");
  new_enable_a: assert property ((NEW_ENABLE != 8'h00) |=>
    ((cal_q & $past(NEW_ENABLE)) == $past(NEW_ENABLE)))
    else $error("new input did not request calibration");
  cal_fail_a: assert property ((st_q == CAL_WAIT) && CAL_DONE && !cal_ok
    && !wr_cal |=> CAL_FAIL && cal_q[$past(cmd_q.sel)])
    else $error("failed calibration not flagged");
  alert_cause_a: assert property ($fell(ALERT_N) |->
    ($past(evt & mask_q) != 8'h00))
    else $error("alert asserted without unmasked event");
  alert_set_a: assert property (((evt & mask_q) != 8'h00) |=> !ALERT_N)
    else $error("unmasked event did not assert alert");
  block_limit_a: assert property (blk_en |=>
    ($countones(sel_q) <= $past(lim)))
    else $error("accepted touches above limit");
  no_block_a: assert property (!blk_en |=> (sel_q == $past(TOUCH_DET)))
    else $error("touch blocked with blocking disabled");
  multi_touch_status_flag_a: assert property (blk_en &&
    ($countones(TOUCH_DET) > lim) |=> MULTI_TOUCH)
    else $error("multi-touch status not set");
  keep_accepted_a: assert property (blk_en &&
    ((sel_q & ~TOUCH_DET) == 8'h00) && ($countones(sel_q) <= lim) |=>
    ((sel_q & $past(sel_q)) == $past(sel_q)))
    else $error("accepted input dropped while held");
  cal_order_a: assert property (CAL_CMD.start |->
    ((($past(pend) << (3'd7 - CAL_CMD.sel)) & 8'h7F) == 8'h00))
    else $error("calibration not in ascending order");

  cal_fail_c: cover property ((st_q == CAL_WAIT) && CAL_DONE && !cal_ok);
  block_c: cover property (MULTI_TOUCH && blk_en);
  alert_c: cover property ($fell(ALERT_N));
  repeat_c: cover property (evt[2] ##[2:60] evt[2]);

endmodule

// File: rtl/tch_pkg.sv
package tch_pkg;

  localparam int NUM_IN = 8;
  localparam int CAL_W = 10;
  localparam int CODE_W = 4;

  // Register offsets
  localparam logic [7:0] ADDR_CAL = 8'h26;
  localparam logic [7:0] ADDR_MASK = 8'h27;
  localparam logic [7:0] ADDR_RPT = 8'h28;
  localparam logic [7:0] ADDR_MT = 8'h2A;

  // Reset values
  localparam logic [7:0] RST_CAL = 8'h00;
  localparam logic [7:0] RST_MASK = 8'hFF;
  localparam logic [7:0] RST_RPT = 8'hFF;
  localparam logic [7:0] RST_MT = 8'h80;

  // Simultaneous-touch configuration fields
  localparam int MT_EN_BIT = 7;
  localparam int MT_LIM_LSB = 2;
  localparam int MT_LIM_W = 2;
  localparam logic [7:0] MT_WMASK = 8'h8C;

  // Calibration value limits
  localparam logic [CAL_W-1:0] CAL_MAX = 10'h3FF;
  localparam logic [CAL_W-1:0] CAL_MIN = 10'h000;

  // Step of the repeat and hold timers
  localparam int STEP_TIME_US = 35000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STEP_CYCLES_DEF = STEP_TIME_US * 1000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tch_reg_s;

  typedef struct packed {
    logic start;
    logic [2:0] sel;
  } tch_cal_s;

  typedef enum logic {
    CAL_IDLE,
    CAL_WAIT
  } tch_cal_e;

endpackage

// File: rtl/tch_rpt.sv
`timescale 1ns/10ps
module tch_rpt (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic touch,
  input wire logic tick,
  input wire logic rpt_en,
  input wire logic rel_en,
  input wire logic [3:0] hold_code,
  input wire logic [3:0] rate_code,
  output logic evt
);
  logic prev_q, prev_d;
  logic hold_q, hold_d;
  logic [4:0] held_q, held_d;
  logic [3:0] rep_q, rep_d;
  logic evt_q, evt_d;

  assign evt = evt_q;

  always_comb begin
    prev_d = touch;
    hold_d = hold_q;
    held_d = held_q;
    rep_d = rep_q;
    evt_d = 1'b0;
    if (touch && !prev_q) begin
      // New touch: one event, timers restart
      evt_d = 1'b1;
      hold_d = 1'b0;
      held_d = '0;
      rep_d = '0;
    end else if (touch && tick) begin
      if (!hold_q) begin
        // Held past the minimum-press time becomes press-and-hold when repeat is enabled
        if (held_q == ({1'b0, hold_code} + 5'h01)) begin
          hold_d = rpt_en;
          evt_d = rpt_en;
          rep_d = '0;
        end else begin
          held_d = held_q + 5'h01;
        end
      end else if (rep_q == rate_code) begin
        evt_d = rpt_en;
        rep_d = '0;
      end else begin
        rep_d = rep_q + 4'h1;
      end
    end else if (!touch && prev_q) begin
      // Release event only for a plain touch or with repeat disabled
      evt_d = rel_en && !hold_q;
      hold_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_q <= 1'b0;
      hold_q <= 1'b0;
      held_q <= '0;
      rep_q <= '0;
      evt_q <= 1'b0;
    end else begin
      prev_q <= prev_d;
      hold_q <= hold_d;
      held_q <= held_d;
      rep_q <= rep_d;
      evt_q <= evt_d;
    end
  end

endmodule

// File: tb/tch_cal_model.sv
`timescale 1ns/10ps
module tch_cal_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire tch_pkg::tch_cal_s cmd,
  input wire logic [7:0] fail_mask,
  input wire logic [3:0] lag,
  output logic done,
  output logic [9:0] result
);
  import tch_pkg::*;
  logic [4:0] cnt;
  logic [2:0] sel;
  // Answers lag+1 cycles after start; result toggles when not valid
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      sel <= '0;
      done <= 1'b0;
      result <= 10'h2AA;
    end else begin
      done <= 1'b0;
      result <= ~result;
      if (cmd.start) begin
        cnt <= {1'b0, lag} + 5'h01;
        sel <= cmd.sel;
      end else if (cnt != 5'h00) begin
        cnt <= cnt - 5'h01;
        if (cnt == 5'h01) begin
          done <= 1'b1;
          result <= fail_mask[sel] ? CAL_MAX : {7'h40, sel};
        end
      end
    end
  end
endmodule

// File: tb/tb_tch_ctrl.sv
`timescale 1ns/10ps
module tb_tch_ctrl;
  import tch_pkg::*;
  localparam int STEP = 20;
  logic clk, rst_n, rel_en, sclr, done, mt, cfail, alert_n;
  tch_reg_s req;
  tch_cal_s cmd;
  logic [7:0] rdata, touch, noise, newen, stat, fail_mask;
  logic [3:0] rptc, holdc, lag;
  logic [9:0] result;
  logic [79:0] calv;
  logic [7:0] ra [5] = '{ADDR_CAL, ADDR_MASK, ADDR_RPT, ADDR_MT, 8'h29};
  logic [7:0] rv [5] = '{RST_CAL, RST_MASK, RST_RPT, RST_MT, 8'h00};
  int mismatches, n_compared;

  tch_ctrl #(.STEP_CYCLES(STEP)) i_tch_ctrl (.SYS_CLK(clk), .ARST_N(rst_n),
    .REG_REQ(req), .REG_RDATA(rdata), .TOUCH_DET(touch),
    .NOISE_FLAG(noise), .NEW_ENABLE(newen), .RELEASE_INT_EN(rel_en),
    .REPEAT_CODE(rptc), .HOLD_CODE(holdc), .STATUS_CLEAR(sclr),
    .CAL_DONE(done), .CAL_RESULT(result), .CAL_CMD(cmd),
    .CAL_VALUES(calv), .TOUCH_STATUS(stat), .MULTI_TOUCH(mt),
    .CAL_FAIL(cfail), .ALERT_N(alert_n));
  tch_cal_model i_tch_cal_model (.clk(clk), .rst_n(rst_n), .cmd(cmd),
    .fail_mask(fail_mask), .lag(lag), .done(done), .result(result));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    cyc(1);
    req.wr = 1'b0;
    // Let an edge pass so a following request never retimes the strobe
    cyc(1);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] exp);
    req = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    req.rd = 1'b0;
    cyc(1);
    chk("rdata", {2'b00, exp}, {2'b00, rdata});
  endtask

  task automatic cal_wait(int n);
    for (int i = 0; i < 400 && n > 0; i++) begin
      cyc(1);
      if (done === 1'b1) n--;
    end
    chk("cal_done", 10'h000, 10'(n));
    cyc(3);
  endtask

  // Returns early once the alert line is low
  task automatic alert_by(int n, logic exp);
    for (int i = 0; i < n && alert_n !== 1'b0; i++) cyc(1);
    chk("alert_n", {9'h000, exp}, {9'h000, alert_n});
  endtask

  task automatic clear;
    sclr = 1'b1;
    cyc(1);
    sclr = 1'b0;
  endtask

  initial begin
    #300000;
    mismatches++;
    final_report();
  end

  initial begin
    rst_n = 1'b0;
    req = '0;
    touch = 8'h00;
    noise = 8'h00;
    newen = 8'h00;
    rel_en = 1'b0;
    rptc = 4'h1;
    holdc = 4'h3;
    sclr = 1'b0;
    fail_mask = 8'h00;
    lag = 4'h2;
    mismatches = 0;
    n_compared = 0;
    cyc(8);
    rst_n = 1'b1;
    for (int i = 0; i < 5; i++) rd(ra[i], rv[i]);
    wr(ADDR_MT, 8'hFF);
    rd(ADDR_MT, MT_WMASK);
    wr(ADDR_CAL, 8'h05);
    cal_wait(1);
    chk("cal1", 10'h200, calv[9:0]);
    chk("cal3", 10'h000, calv[29:20]);
    cal_wait(1);
    chk("cal3", 10'h202, calv[29:20]);
    rd(ADDR_CAL, 8'h00);
    chk("cal_fail", 10'h000, {9'h000, cfail});
    fail_mask = 8'h02;
    wr(ADDR_CAL, 8'h02);
    cal_wait(1);
    rd(ADDR_CAL, 8'h02);
    chk("cal_fail", 10'h001, {9'h000, cfail});
    clear();
    chk("cal_fail", 10'h000, {9'h000, cfail});
    noise = 8'h08;
    wr(ADDR_CAL, 8'h0A);
    cal_wait(2);
    rd(ADDR_CAL, 8'h0A);
    chk("cal_fail", 10'h001, {9'h000, cfail});
    noise = 8'h00;
    fail_mask = 8'h00;
    wr(ADDR_CAL, 8'h00);
    clear();
    lag = 4'h8;
    wr(ADDR_CAL, 8'hC0);
    cyc(1);
    wr(ADDR_CAL, 8'h40);
    cal_wait(1);
    cyc(20);
    rd(ADDR_CAL, 8'h00);
    chk("cal8", 10'h000, calv[79:70]);
    chk("cal7", 10'h206, calv[69:60]);
    newen = 8'h10;
    cyc(1);
    newen = 8'h00;
    rd(ADDR_CAL, 8'h10);
    cal_wait(1);
    rd(ADDR_CAL, 8'h00);
    lag = 4'h2;
    wr(ADDR_MASK, 8'hFE);
    wr(ADDR_RPT, 8'h00);
    touch = 8'h01;
    alert_by(6, 1'b1);
    chk("status", 10'h001, {2'b00, stat});
    touch = 8'h00;
    cyc(4);
    touch = 8'h02;
    alert_by(6, 1'b0);
    clear();
    alert_by(8 * STEP, 1'b1);
    rel_en = 1'b1;
    touch = 8'h00;
    alert_by(6, 1'b0);
    wr(ADDR_RPT, 8'hFF);
    clear();
    touch = 8'h04;
    alert_by(6, 1'b0);
    clear();
    cyc(3);
    touch = 8'h00;
    alert_by(6, 1'b0);
    clear();
    touch = 8'h04;
    alert_by(6, 1'b0);
    clear();
    alert_by(3 * STEP - 10, 1'b1);
    alert_by(3 * STEP, 1'b0);
    clear();
    alert_by(30, 1'b1);
    alert_by(20, 1'b0);
    touch = 8'h00;
    cyc(2);
    clear();
    alert_by(6, 1'b1);
    rel_en = 1'b0;
    wr(ADDR_MT, 8'h84);
    touch = 8'h06;
    cyc(2);
    chk("status", 10'h006, {2'b00, stat});
    touch = 8'h07;
    cyc(2);
    chk("status", 10'h006, {2'b00, stat});
    chk("multi", 10'h001, {9'h000, mt});
    touch = 8'h0D;
    cyc(2);
    chk("status", 10'h005, {2'b00, stat});
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_MT, 8'h80 | 8'(k << 2));
      touch = 8'h00;
      cyc(2);
      touch = 8'hFF;
      cyc(2);
      chk("status", 10'((2 << k) - 1), {2'b00, stat});
    end
    wr(ADDR_MT, 8'h00);
    cyc(2);
    chk("status", 10'h0FF, {2'b00, stat});
    chk("multi", 10'h000, {9'h000, mt});
    final_report();
  end
endmodule
